/* verilog/stp_port.v */
// scsi target port: registers, identity match, parity, command sequencer
// assumes an 8 MHz system clock and an async active-low system reset
//
// Notes on behaviour
// - interrupt is done flag and-ed with interrupt enable command bit 7
// - parity fault flag set on a transfer fault with local select clear; local select tells bus or memory source
// - status bits 5..2 show bus reset, attention, select, busy levels
// - status bit 1 shows arbitration won and bus held
// - status bit 0 is identity match; with select means port selected
// - identity register keeps three low bits; upper bits unused
// - codes 100 disconnect,101 transfer,110 reselect,111 arbitrate; needs enable
// - arbitrate waits for bus free, arbitrates, completes on a win
// - lost arbitration returns to watching for bus free, no completion
// - reselect fetches identity byte by dma, drives it, waits for response
// - disconnect releases the bus and completes
// - all logic runs on one 8 MHz clock
// - whole port initialised by active-low system reset
// - per byte request; dma answers cycle strobe, terminal count at zero
// - host uses two address bits, block select, read strobe; low irq
// - bus inputs registered before sequencer and status use them
// - transfer handshake: assert req, wait for initiator ack per byte, except the last byte with local select clear
// - six-bit state; power-up 3FH, idle 1FH, selected 3CH,18H,19H,1AH
// - bus reset forces any state to first completion, disconnect outputs
// - bus parity computed; fault when received parity differs while select is asserted
`timescale 1ns/10ps
`include "stp_regs.vh"
module stp_port #(
    parameter ARB_DLY = 4'hF
) (
    // clock and reset
    input  wire       CLK,
    input  wire       RST_B,
    // host register port
    input  wire [1:0] ADDR,
    input  wire       SEL_B,
    input  wire       RD_B,
    input  wire [7:0] WDATA,
    output reg  [7:0] RDATA,
    output reg        IRQ_B_O,
    output reg        IRQ_B_OE,
    // dma controller
    output reg        DMA_REQ,
    input  wire       DMA_CYCLE_B,
    input  wire       DMA_TC_B,
    output reg        DMA_EN,
    // local memory byte path
    input  wire [7:0] MEM_DATA,
    output reg  [7:0] MEM_WDATA,
    // scsi bus inputs
    input  wire [7:0] BUS_D_I,
    input  wire       BUS_P_I,
    input  wire       BUS_RST,
    input  wire       BUS_ATN,
    input  wire       BUS_SEL,
    input  wire       BUS_BSY,
    input  wire       BUS_ACK,
    // scsi bus drives
    output reg  [7:0] BUS_D_O,
    output reg        BUS_P_O,
    output reg        BUS_D_OE,
    output reg        BUS_BSY_O,
    output reg        BUS_SEL_O,
    output reg        BUS_REQ_O,
    output reg        BUS_MSG_O,
    output reg        BUS_CD_O,
    output reg        BUS_IO_O
);
    reg  [7:0] cmd_q;
    reg  [2:0] id_q;
    reg  [5:0] st_q;
    reg  [5:0] st_d;
    reg  [3:0] dly_q;
    reg        done_q;
    reg        parity_fault_flag_q;
    reg        arb_q;
    reg        req_q;
    reg        drv_q;
    reg        bsy_q;
    reg        sel_q;
    reg        dma_request_line_q;
    reg        wr_q;
    reg  [7:0] din_q;
    wire [7:0] bd;
    wire [5:0] bl;
    wire [1:0] dl;
    wire       b_par = bl[5];
    wire       b_rst = bl[4];
    wire       b_atn = bl[3];
    wire       b_sel = bl[2];
    wire       b_bsy = bl[1];
    wire       b_ack = bl[0];
    wire       dma_cyc = ~dl[1];
    wire       dma_tc  = ~dl[0];
    wire [2:0] op = {cmd_q[`STP_CMD_PORT_ENABLE_BIT], cmd_q[`STP_CMD_FC_HI],
                     cmd_q[`STP_CMD_FC_LO]};
    wire       pen = cmd_q[`STP_CMD_PORT_ENABLE_BIT];
    wire       local_side_select = cmd_q[`STP_CMD_LOCAL_SIDE_SELECT];
    wire [7:0] id_bit = 8'h01 << id_q;
    wire       match = |(bd & id_bit);
    wire       higher = |(bd & ~((id_bit << 1) - 8'h01));
    wire       won = match & ~higher;
    wire       par_gen = ~^bd;
    wire       par_err = (par_gen != b_par) & b_sel;
    wire [7:0] status = {done_q, parity_fault_flag_q, b_rst, b_atn, b_sel,
                         b_bsy, arb_q, match};
    wire       bfree = ~b_bsy & ~b_sel;
    wire       wr_now = ~SEL_B & RD_B;
    wire       wr_edge = wr_now & ~wr_q;
    wire       bf_valid;
    wire       bf_ready;
    wire [7:0] bf_data;
    wire       bf_in_ready;
    wire [7:0] bus_d_nx = (st_q == `STP_S_ARBD) ? id_bit :
                          dma_cyc ? (bf_valid ? bf_data : MEM_DATA) : BUS_D_O;

    // bus levels resynchronised
    stp_sync #(.W(14)) u_bsync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .din   ({BUS_D_I, BUS_P_I, BUS_RST, BUS_ATN, BUS_SEL, BUS_BSY,
                 BUS_ACK}),
        .dout  ({bd, bl})
    );

    // dma strobes resynchronised
    stp_sync #(.W(2)) u_dsync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .din   ({DMA_CYCLE_B, DMA_TC_B}),
        .dout  (dl)
    );

    // outbound byte buffer toward the bus
    stp_buf2 #(.W(8)) u_buf (
        .CLK       (CLK),
        .RST_B     (RST_B),
        .in_valid  (wr_edge & (ADDR == `STP_ADDR_DATA)),
        .in_ready  (bf_in_ready),
        .in_data   (WDATA),
        .out_valid (bf_valid),
        .out_ready (bf_ready),
        .out_data  (bf_data)
    );
    // drain one byte per dma cycle taken from the bus side
    assign bf_ready = dma_request_line_q & dma_cyc & ~local_side_select;

    // host writes on falling select with read strobe high
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_q <= `STP_CMD_RST;
            id_q  <= `STP_ID_RST;
            wr_q  <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            wr_q <= wr_now;
            if (wr_edge & (ADDR == `STP_ADDR_CMD))
                cmd_q <= WDATA;
            if (wr_edge & (ADDR == `STP_ADDR_ID))
                id_q <= WDATA[2:0];
            if (~SEL_B & ~RD_B) begin
                case (ADDR)
                    `STP_ADDR_STAT: RDATA <= status;
                    `STP_ADDR_DATA: RDATA <= din_q;
                    default:        RDATA <= 8'h00;
                endcase
            end
        end
    end

    // sequencer next state
    always @* begin
        st_d = st_q;
        if (b_rst)
            st_d = `STP_S_CMP1;
        else begin
            case (st_q)
                `STP_S_PWRUP: st_d = `STP_S_IDLE;
                `STP_S_IDLE: begin
                    if (op == `STP_OP_DISC && bsy_q)
                        st_d = `STP_S_CMP1;
                    else if (op == `STP_OP_RESEL && bfree && bsy_q)
                        st_d = `STP_S_RES1;
                    else if (pen && !bsy_q && !b_bsy && b_sel && match &&
                             !par_err)
                        st_d = `STP_S_SEL1;
                    else if (op == `STP_OP_ARB && !bsy_q && bfree)
                        st_d = `STP_S_ARB1;
                    else if (op == `STP_OP_XFER && bsy_q)
                        st_d = `STP_S_XF1;
                end
                `STP_S_RES1: if (dma_cyc) st_d = `STP_S_RES2;
                `STP_S_RES2: st_d = `STP_S_RES3;
                `STP_S_RES3: st_d = `STP_S_RES4;
                `STP_S_RES4: st_d = `STP_S_RES5;
                `STP_S_RES5: if (!bsy_q) st_d = `STP_S_RES6;
                `STP_S_RES6: if (b_bsy) st_d = `STP_S_CMP1;
                `STP_S_SEL1: if (!pen && dma_cyc) st_d = `STP_S_SEL2;
                `STP_S_SEL2: st_d = `STP_S_SEL3;
                `STP_S_SEL3: st_d = `STP_S_SEL4;
                `STP_S_SEL4: if (pen) st_d = `STP_S_CMP1;
                `STP_S_ARB1: begin
                    if (!bfree)
                        st_d = `STP_S_IDLE;
                    else
                        st_d = `STP_S_ARBD;
                end
                `STP_S_ARBD: if (dly_q == ARB_DLY) st_d = `STP_S_ARB2;
                `STP_S_ARB2: begin
                    if (b_sel)
                        st_d = `STP_S_IDLE;
                    else if (won)
                        st_d = `STP_S_CMP1;
                end
                `STP_S_XF1: if (pen && dma_cyc && dma_request_line_q) st_d = `STP_S_XF2;
                `STP_S_XF2: st_d = `STP_S_XF3;
                `STP_S_XF3: st_d = `STP_S_XF4;
                `STP_S_XF4: begin
                    if (!pen)
                        st_d = `STP_S_CMP1;
                    else if (par_err & ~local_side_select)
                        st_d = `STP_S_CMP1;
                    else if (dma_tc)
                        st_d = local_side_select ? `STP_S_XF5 : `STP_S_CMP1;
                    else
                        st_d = `STP_S_XF1;
                end
                `STP_S_XF5: if (b_ack) st_d = `STP_S_CMP1;
                `STP_S_CMP1: if (!pen) st_d = `STP_S_CMP2;
                `STP_S_CMP2: if (pen) st_d = `STP_S_IDLE;
                default: st_d = `STP_S_IDLE;
            endcase
        end
    end

    // sequencer registers and bus drives
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q     <= `STP_S_PWRUP;
            dly_q    <= 4'h0;
            done_q   <= 1'b0;
            parity_fault_flag_q   <= 1'b0;
            arb_q    <= 1'b0;
            req_q    <= 1'b0;
            drv_q    <= 1'b0;
            bsy_q    <= 1'b0;
            sel_q    <= 1'b0;
            dma_request_line_q <= 1'b0;
            din_q    <= 8'h00;
        end else begin
            st_q  <= st_d;
            dly_q <= (st_q == `STP_S_ARBD) ? dly_q + 4'h1 : 4'h0;
            if (b_rst) begin
                bsy_q    <= 1'b0;
                sel_q    <= 1'b0;
                req_q    <= 1'b0;
                arb_q    <= 1'b0;
                drv_q    <= 1'b0;
                dma_request_line_q <= 1'b0;
                done_q   <= 1'b1;
            end else begin
                if (st_q == `STP_S_IDLE && st_d == `STP_S_CMP1) begin
                    bsy_q  <= 1'b0;
                    sel_q  <= 1'b0;
                    drv_q  <= 1'b0;
                    arb_q  <= 1'b0;
                    done_q <= 1'b1;
                end
                if (st_d == `STP_S_RES1 && st_q == `STP_S_IDLE) begin
                    bsy_q    <= 1'b1;
                    sel_q    <= 1'b1;
                    drv_q    <= 1'b1;
                    dma_request_line_q <= 1'b1;
                end
                if (st_q == `STP_S_RES1 && dma_cyc)
                    dma_request_line_q <= 1'b0;
                if (st_q == `STP_S_RES5 && bsy_q)
                    bsy_q <= 1'b0;
                if (st_q == `STP_S_RES6 && st_d == `STP_S_CMP1) begin
                    bsy_q  <= 1'b1;
                    sel_q  <= 1'b0;
                    done_q <= 1'b1;
                end
                if (st_d == `STP_S_SEL1 && st_q == `STP_S_IDLE) begin
                    done_q   <= 1'b1;
                    dma_request_line_q <= 1'b1;
                end
                if (st_q == `STP_S_SEL1 && st_d == `STP_S_SEL2) begin
                    bsy_q    <= 1'b1;
                    drv_q    <= 1'b1;
                    done_q   <= 1'b0;
                    dma_request_line_q <= 1'b0;
                end
                if (st_q == `STP_S_SEL3)
                    done_q <= 1'b1;
                if (st_q == `STP_S_ARB1 && st_d == `STP_S_ARBD) begin
                    bsy_q <= 1'b1;
                    drv_q <= 1'b1;
                end
                if (st_q == `STP_S_ARB2 && st_d == `STP_S_CMP1) begin
                    sel_q  <= 1'b1;
                    arb_q  <= 1'b1;
                    done_q <= 1'b1;
                end
                if (st_q == `STP_S_ARB2 && st_d == `STP_S_IDLE) begin
                    bsy_q <= 1'b0;
                    drv_q <= 1'b0;
                end
                if (st_q == `STP_S_IDLE && st_d == `STP_S_XF1) begin
                    req_q    <= local_side_select;
                    dma_request_line_q <= ~local_side_select;
                end
                if (st_q == `STP_S_XF1 && req_q && b_ack) begin
                    req_q    <= 1'b0;
                    dma_request_line_q <= 1'b1;
                    din_q    <= bd;
                end
                if (st_q == `STP_S_XF1 && st_d == `STP_S_XF2)
                    dma_request_line_q <= 1'b0;
                if (st_q == `STP_S_XF4) begin
                    if (st_d == `STP_S_CMP1)
                        done_q <= 1'b1;
                    if (par_err & ~local_side_select)
                        parity_fault_flag_q <= 1'b1;
                    if (st_d == `STP_S_XF5 || st_d == `STP_S_XF1)
                        req_q <= 1'b1;
                end
                if (st_q == `STP_S_XF5 && b_ack) begin
                    req_q  <= 1'b0;
                    done_q <= 1'b1;
                end
                if (st_q == `STP_S_CMP1 && !pen) begin
                    done_q <= 1'b0;
                    parity_fault_flag_q <= 1'b0;
                end
            end
        end
    end

    // registered pins
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_B_O   <= 1'b0;
            IRQ_B_OE  <= 1'b0;
            DMA_REQ   <= 1'b0;
            DMA_EN    <= 1'b0;
            MEM_WDATA <= 8'h00;
            BUS_D_O   <= 8'h00;
            BUS_P_O   <= 1'b0;
            BUS_D_OE  <= 1'b0;
            BUS_BSY_O <= 1'b0;
            BUS_SEL_O <= 1'b0;
            BUS_REQ_O <= 1'b0;
            BUS_MSG_O <= 1'b0;
            BUS_CD_O  <= 1'b0;
            BUS_IO_O  <= 1'b0;
        end else begin
            IRQ_B_O   <= 1'b0;
            IRQ_B_OE  <= done_q & cmd_q[`STP_CMD_IRQ_ENABLE_BIT];
            DMA_REQ   <= dma_request_line_q;
            DMA_EN    <= cmd_q[`STP_CMD_DMA_ENABLE_BIT];
            MEM_WDATA <= din_q;
            BUS_D_O   <= bus_d_nx;
            BUS_P_O   <= ~^bus_d_nx;
            BUS_D_OE  <= drv_q & ~local_side_select;
            BUS_BSY_O <= bsy_q;
            BUS_SEL_O <= sel_q;
            BUS_REQ_O <= req_q;
            BUS_MSG_O <= cmd_q[`STP_CMD_MESSAGE_PHASE_BIT];
            BUS_CD_O  <= cmd_q[`STP_CMD_CTRL];
            BUS_IO_O  <= ~local_side_select;
        end
    end
endmodule

/* pkg/stp_regs.vh */
// constants for the scsi target port: register offsets, fields, states
// assumes inclusion once per design file by bare name
`ifndef STP_REGS_VH
`define STP_REGS_VH
// register addresses on the two low address bits
`define STP_ADDR_STAT    2'h0
`define STP_ADDR_CMD     2'h0
`define STP_ADDR_ID      2'h1
`define STP_ADDR_DATA    2'h2
// command register fields
`define STP_CMD_IRQ_ENABLE_BIT     7
`define STP_CMD_PORT_ENABLE_BIT    6
`define STP_CMD_DMA_ENABLE_BIT     5
`define STP_CMD_LOCAL_SIDE_SELECT     4
`define STP_CMD_MESSAGE_PHASE_BIT     3
`define STP_CMD_CTRL     2
`define STP_CMD_FC_HI    1
`define STP_CMD_FC_LO    0
// status register fields
`define STP_ST_DONE      7
`define STP_ST_PARITY_FAULT_FLAG      6
`define STP_ST_RST       5
`define STP_ST_ATN       4
`define STP_ST_SEL       3
`define STP_ST_BSY       2
`define STP_ST_ARB       1
`define STP_ST_MATCH     0
// commands on {port enable, function code}
`define STP_OP_DISC      3'h4
`define STP_OP_XFER      3'h5
`define STP_OP_RESEL     3'h6
`define STP_OP_ARB       3'h7
// sequencer state codes
`define STP_S_PWRUP      6'h3F
`define STP_S_IDLE       6'h1F
`define STP_S_SEL1       6'h3C
`define STP_S_SEL2       6'h18
`define STP_S_SEL3       6'h19
`define STP_S_SEL4       6'h1A
`define STP_S_RES1       6'h10
`define STP_S_RES2       6'h11
`define STP_S_RES3       6'h12
`define STP_S_RES4       6'h13
`define STP_S_RES5       6'h3B
`define STP_S_RES6       6'h33
`define STP_S_ARB1       6'h00
`define STP_S_ARB2       6'h0F
`define STP_S_ARBD       6'h20
`define STP_S_ARBQ       6'h2E
`define STP_S_XF1        6'h14
`define STP_S_XF2        6'h15
`define STP_S_XF3        6'h16
`define STP_S_XF4        6'h17
`define STP_S_XF5        6'h34
`define STP_S_XFSL       6'h1A
`define STP_S_CMP1       6'h1C
`define STP_S_CMP2       6'h1E
// reset values
`define STP_CMD_RST      8'h00
`define STP_ID_RST       3'h0
`endif

/* verilog/stp_sync.v */
// two-stage synchroniser for a group of bus input levels
// assumes inputs asynchronous to CLK
`timescale 1ns/10ps
module stp_sync #(
    parameter W = 8
) (
    // clock and reset
    input  wire         CLK,
    input  wire         RST_B,
    // levels
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

/* verilog/stp_buf2.v */
// two-entry buffer with valid/ready on both sides
// assumes one clock domain
`timescale 1ns/10ps
module stp_buf2 #(
    parameter W = 8
) (
    // clock and reset
    input  wire         CLK,
    input  wire         RST_B,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_q [0:1];
    reg         wp_q;
    reg         rp_q;
    reg [1:0]   cnt_q;
    wire        push = in_valid & in_ready;
    wire        pop  = out_valid & out_ready;
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mem_q[0] <= {W{1'b0}};
            mem_q[1] <= {W{1'b0}};
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            if (push & ~pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule

/* verification/stp_port_assertions.sv */
// checker for the scsi target port pins, bound into stp_port
// assumes one clock and the async active-low reset
`timescale 1ns/10ps
module stp_port_chk #(
    parameter ARB_DLY = 4'hF
) (
    // clock and reset
    input wire       CLK,
    input wire       RST_B,
    // host side
    input wire [1:0] ADDR,
    input wire       SEL_B,
    input wire       RD_B,
    input wire [7:0] WDATA,
    input wire [7:0] RDATA,
    input wire       IRQ_B_O,
    input wire       IRQ_B_OE,
    // dma and bus
    input wire       DMA_REQ,
    input wire       DMA_EN,
    input wire       BUS_RST,
    input wire       BUS_ATN,
    input wire       BUS_SEL,
    input wire       BUS_BSY,
    input wire [7:0] BUS_D_O,
    input wire       BUS_P_O,
    input wire       BUS_D_OE,
    input wire       BUS_BSY_O,
    input wire       BUS_SEL_O,
    input wire       BUS_REQ_O
);
    reg  [7:0] cmd_q;
    reg        wr_q;
    reg        en_q;
    reg  [3:0] lvl_q;
    reg  [2:0] cnt_q;
    wire [3:0] lvl = {BUS_RST, BUS_ATN, BUS_SEL, BUS_BSY};
    wire       hold = !SEL_B && !RD_B && ADDR == 2'h0 && lvl == lvl_q;

    // command shadow, level stability count
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_q <= 8'h00;
            wr_q  <= 1'b0;
            en_q  <= 1'b0;
            lvl_q <= 4'h0;
            cnt_q <= 3'h0;
        end else begin
            wr_q  <= !SEL_B && RD_B;
            if (!SEL_B && RD_B && !wr_q && ADDR == 2'h0)
                cmd_q <= WDATA;
            en_q  <= en_q | cmd_q[6];
            lvl_q <= lvl;
            cnt_q <= !hold ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_irq_gated: assert property (!cmd_q[7] [*3] |-> !IRQ_B_OE)
        else $error("interrupt while disabled");
    a_irq_drops: assert property ($fell(cmd_q[6]) |-> ##[1:4] !IRQ_B_OE)
        else $error("interrupt stuck");
    a_irq_pin_low: assert property (IRQ_B_O == 1'b0)
        else $error("interrupt pin driven high");
    a_dma_en_copy: assert property
        ($stable(cmd_q[5]) [*3] |-> DMA_EN == cmd_q[5])
        else $error("dma enable differs");
    a_odd_parity: assert property (BUS_D_OE |-> BUS_P_O == ~^BUS_D_O)
        else $error("bus parity not odd");
    a_reset_quiet: assert property (BUS_RST [*5] |->
        !(BUS_BSY_O | BUS_SEL_O | BUS_REQ_O | BUS_D_OE | DMA_REQ))
        else $error("bus driven in bus reset");
    a_status_lines: assert property
        (cnt_q > 3'h3 && hold |-> RDATA[5:2] == lvl)
        else $error("status levels differ");
    a_idle_quiet: assert property (!en_q && !cmd_q[6] |->
        !BUS_BSY_O && !BUS_D_OE)
        else $error("bus driven while port disabled");
    a_unmapped_zero: assert property
        ((!SEL_B && !RD_B && ADDR == 2'h3) [*2] |-> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_sel_with_busy: assert property ($rose(BUS_SEL_O) |-> BUS_BSY_O)
        else $error("select without busy");

    c_irq: cover property ($rose(IRQ_B_OE));
    c_won: cover property ($rose(BUS_SEL_O));
    c_lost: cover property ($fell(BUS_BSY_O) && !BUS_SEL_O);
endmodule

/* verification/stp_far_end.sv */
// far-end model: bus initiators, wire-or bus and the local dma engine
// assumes the bench sets line levels and a rival arbiter on demand
`timescale 1ns/10ps
module stp_far_end #(
    parameter LAG = 2'h1
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // bench controls
    input  wire       rival,
    input  wire [3:0] lines,
    // port drives
    input  wire       dma_req,
    input  wire       bus_req,
    input  wire       bus_bsy_o,
    input  wire       bus_sel_o,
    input  wire       bus_d_oe,
    input  wire [7:0] bus_d_o,
    // back to the port
    output reg        dma_cycle_b,
    output wire       dma_tc_b,
    output wire [7:0] mem_data,
    output wire [7:0] bus_d_i,
    output wire       bus_p_i,
    output wire       bus_rst,
    output wire       bus_atn,
    output wire       bus_sel,
    output wire       bus_bsy,
    output reg        bus_ack
);
    reg       rival_q;
    reg [3:0] left_q;
    reg [1:0] wait_q;

    // terminated bus reads 0 when released
    assign bus_d_i  = (bus_d_oe ? bus_d_o : 8'h00) | {rival_q, 7'h00};
    assign bus_p_i  = ~^bus_d_i;
    assign bus_rst  = lines[3];
    assign bus_atn  = lines[2];
    assign bus_sel  = lines[1] | bus_sel_o | rival_q;
    assign bus_bsy  = lines[0] | bus_bsy_o;
    assign dma_tc_b = left_q != 4'h0;
    assign mem_data = {4'hA, left_q};

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rival_q     <= 1'b0;
            left_q      <= 4'h3;
            wait_q      <= 2'h0;
            dma_cycle_b <= 1'b1;
            bus_ack     <= 1'b0;
        end else begin
            rival_q <= rival & (bus_bsy_o | rival_q);
            bus_ack <= bus_req;
            wait_q  <= dma_req ? wait_q + 2'h1 : 2'h0;
            if (dma_req && wait_q == LAG && dma_cycle_b) begin
                dma_cycle_b <= 1'b0;
                left_q      <= left_q - {3'h0, left_q != 4'h0};
            end else if (!dma_req)
                dma_cycle_b <= 1'b1;
        end
    end
endmodule

/* verification/test_scsi_target_port_sequencer.sv */
// bench for the scsi target port: host register tasks, bus scenarios
// assumes the far-end model plays the bus initiators and the dma
`timescale 1ns/10ps
module test_scsi_target_port_sequencer;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg  [1:0] addr = 2'h0;
    reg        sel_b = 1'b1;
    reg        rd_b = 1'b1;
    reg  [7:0] wdata = 8'h00;
    reg        rival = 1'b0;
    reg  [3:0] lines = 4'h0;
    reg  [7:0] v;
    wire [7:0] rdata, mem_data, bd_i, bd_o;
    wire       irq_o, irq_oe, dreq, dcyc_b, dtc_b, den, bp_i, bp_o;
    wire       b_rst, b_atn, b_sel, b_bsy, b_ack, bd_oe, bsy_o, sel_o, req_o;
    integer    miscompares = 0;
    integer    samples_checked = 0;
    integer    k;

    always #5 clk = ~clk;

    stp_port #(.ARB_DLY(4'h4)) dut (
        .CLK(clk), .RST_B(rst_b), .ADDR(addr), .SEL_B(sel_b), .RD_B(rd_b),
        .WDATA(wdata), .RDATA(rdata), .IRQ_B_O(irq_o), .IRQ_B_OE(irq_oe),
        .DMA_REQ(dreq), .DMA_CYCLE_B(dcyc_b), .DMA_TC_B(dtc_b), .DMA_EN(den),
        .MEM_DATA(mem_data), .MEM_WDATA(), .BUS_D_I(bd_i), .BUS_P_I(bp_i),
        .BUS_RST(b_rst), .BUS_ATN(b_atn), .BUS_SEL(b_sel), .BUS_BSY(b_bsy),
        .BUS_ACK(b_ack), .BUS_D_O(bd_o), .BUS_P_O(bp_o), .BUS_D_OE(bd_oe),
        .BUS_BSY_O(bsy_o), .BUS_SEL_O(sel_o), .BUS_REQ_O(req_o),
        .BUS_MSG_O(), .BUS_CD_O(), .BUS_IO_O());

    stp_far_end fe (
        .clk(clk), .rst_b(rst_b), .rival(rival), .lines(lines),
        .dma_req(dreq), .bus_req(req_o), .bus_bsy_o(bsy_o),
        .bus_sel_o(sel_o), .bus_d_oe(bd_oe), .bus_d_o(bd_o),
        .dma_cycle_b(dcyc_b), .dma_tc_b(dtc_b), .mem_data(mem_data),
        .bus_d_i(bd_i), .bus_p_i(bp_i), .bus_rst(b_rst), .bus_atn(b_atn),
        .bus_sel(b_sel), .bus_bsy(b_bsy), .bus_ack(b_ack));

    task complete_run;
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input [7:0] got, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task wr(input [1:0] a, input [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        sel_b = 1'b0;
        @(negedge clk);
        sel_b = 1'b1;
    endtask

    task rd(input [1:0] a, output [7:0] d);
        @(negedge clk);
        addr = a;
        rd_b = 1'b0;
        sel_b = 1'b0;
        repeat (6) @(negedge clk);
        d = rdata;
        sel_b = 1'b1;
        rd_b = 1'b1;
    endtask

    function [7:0] probe(input [1:0] s);
        probe = {7'h00, s == 2'h0 ? irq_oe : bsy_o};
    endfunction

    // bounded wait for interrupt (0) or busy drive (1) to reach the expected level; ends the run on timeout
    task await(input [1:0] s, input [7:0] e, input integer n);
        integer i;
        i = 0;
        while (probe(s) !== e && i < n) begin
            @(negedge clk);
            i = i + 1;
        end
        check(probe(s), e);
        if (probe(s) !== e)
            complete_run;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        check({irq_oe, dreq, den, bd_oe, bsy_o, sel_o, req_o, bp_o}, 8'h00);
        rst_b = 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            lines = 4'h1 << k;
            repeat (2) begin
                rd(2'h0, v);
                check(v & 8'h3C, {2'h0, lines, 2'h0});
            end
        end
        lines = 4'h0;
        rd(2'h3, v);
        check(v, 8'h00);
        wr(2'h0, 8'h23);
        repeat (40) @(negedge clk);
        check({5'h00, den, bsy_o, bd_oe}, 8'h04);
        wr(2'h1, 8'hFD);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h83);
        wr(2'h0, 8'hC3);
        await(2'h1, 8'h01, 100);
        check(bd_o, 8'h20);
        await(2'h0, 8'h01, 100);
        check({6'h00, sel_o, bsy_o}, 8'h03);
        rd(2'h0, v);
        check(v & 8'h82, 8'h82);
        wr(2'h0, 8'h43);
        await(2'h0, 8'h00, 10);
        wr(2'h0, 8'h03);
        wr(2'h0, 8'hC4);
        await(2'h1, 8'h00, 20);
        check({7'h00, sel_o}, 8'h00);
        wr(2'h0, 8'h04);
        rival = 1'b1;
        wr(2'h0, 8'h83);
        wr(2'h0, 8'hC3);
        await(2'h1, 8'h01, 100);
        await(2'h1, 8'h00, 100);
        check({7'h00, irq_oe}, 8'h00);
        rival = 1'b0;
        await(2'h0, 8'h01, 200);
        check({6'h00, sel_o, bsy_o}, 8'h03);
        wr(2'h0, 8'h81);
        wr(2'h0, 8'hE1);
        await(2'h0, 8'h01, 200);
        check(bd_o, 8'hA0);
        lines = 4'h8;
        await(2'h1, 8'h00, 10);
        check({6'h00, sel_o, bd_oe}, 8'h00);
        repeat (6) @(negedge clk);
        lines = 4'h0;
        wr(2'h0, 8'h80);
        await(2'h0, 8'h00, 10);
        complete_run;
    end
endmodule

bind stp_port stp_port_chk #(.ARB_DLY(ARB_DLY)) chk (
    .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .SEL_B(SEL_B), .RD_B(RD_B),
    .WDATA(WDATA), .RDATA(RDATA), .IRQ_B_O(IRQ_B_O), .IRQ_B_OE(IRQ_B_OE),
    .DMA_REQ(DMA_REQ), .DMA_EN(DMA_EN), .BUS_RST(BUS_RST),
    .BUS_ATN(BUS_ATN), .BUS_SEL(BUS_SEL), .BUS_BSY(BUS_BSY),
    .BUS_D_O(BUS_D_O), .BUS_P_O(BUS_P_O), .BUS_D_OE(BUS_D_OE),
    .BUS_BSY_O(BUS_BSY_O), .BUS_SEL_O(BUS_SEL_O), .BUS_REQ_O(BUS_REQ_O));
